// ===== hw/aperture_clock_ctrl.sv
// Clock control top: sampling edges, aperture delay codes, coarse ramp and reference capture.
// Assumes one 100 MHz clock, synchronous pin inputs and a strobed register port.
//
// How it works
// - In dual-channel mode only the rising-edge sample enable is raised.
// - In single-channel mode both edge enables are raised, doubling the sample rate.
// - Single-channel mode widens the reference capture window to two taps.
// - A lone reference pulse and a periodic reference are both captured on each rising edge.
// - The reference is registered through a fixed pipeline so the capture edge repeats every start.
// - The invert bit passes to the delay output as a half-period shift of the clock.
// - Coarse and fine codes are eight bits, giving 256 settings each.
// - Invert, coarse and fine are separate fields that combine freely.
// - The applied delay code goes to apertureDelay and its coarse part to the status register, not to capture; the position select sets the capture point.
// - Delay registers stay writable at any time with no lock.
// - With ramp enabled a coarse write steps the applied value instead of jumping.
// - The slow ramp moves one step per 256 cycles, the fast one four per 384.
// - With ramp enabled a coarse write starts a ramp only when idle and off target; a write mid-ramp only moves the target.
`default_nettype none
module aperture_clock_ctrl
    import aperture_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Register port.
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [DATA_W-1:0] rdData,
    // Timing reference from the clock source.
    input wire logic sysrefIn,
    // Clock tree controls.
    output delay_cfg_t apertureDelay,
    output sample_edges_t sampleEdges,
    output logic sysrefCapture
);

////////////////////////////////////////////////////////////////////////////////
// Reset release.

    logic resetMeta_reg;
    logic resetSync_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            resetMeta_reg <= 1'b0;
            resetSync_reg <= 1'b0;
        end else begin
            resetMeta_reg <= 1'b1;
            resetSync_reg <= resetMeta_reg;
        end
    end

    wire logic resetSync_n = resetSync_reg;

////////////////////////////////////////////////////////////////////////////////
// Register decode.

    wire logic hitCtrl = (addr == CTRL_OFS);
    wire logic hitCoarse = (addr == COARSE_OFS);
    wire logic hitFine = (addr == FINE_OFS);
    wire logic hitStatus = (addr == STATUS_OFS);
    wire logic hitCount = (addr == REFCOUNT_OFS);

    // No lock on these writes: a live change may briefly upset the serial link.
    wire logic wrCtrl = wrStrobe & hitCtrl;
    wire logic wrCoarse = wrStrobe & hitCoarse;
    wire logic wrFine = wrStrobe & hitFine;

////////////////////////////////////////////////////////////////////////////////
// Control registers.

    logic invert_reg;
    logic single_reg;
    logic rampEn_reg;
    logic rampFast_reg;
    logic [SEL_W-1:0] posSel_reg;
    logic [DELAY_W-1:0] coarseTarget_reg;
    logic [DELAY_W-1:0] fine_reg;
    logic coarseWrite_reg;

    always_ff @(posedge clock or negedge resetSync_n) begin
        if (!resetSync_n) begin
            invert_reg <= 1'b0;
            single_reg <= 1'b0;
            rampEn_reg <= 1'b0;
            rampFast_reg <= 1'b0;
            posSel_reg <= SEL_RESET;
        end else if (wrCtrl) begin
            invert_reg <= wrData[CTRL_INV_BIT];
            single_reg <= wrData[CTRL_SINGLE_BIT];
            rampEn_reg <= wrData[CTRL_RAMP_EN_BIT];
            rampFast_reg <= wrData[CTRL_RAMP_FAST_BIT];
            posSel_reg <= wrData[CTRL_SEL_LSB +: SEL_W];
        end
    end

    always_ff @(posedge clock or negedge resetSync_n) begin
        if (!resetSync_n) begin
            coarseTarget_reg <= DELAY_RESET;
            fine_reg <= DELAY_RESET;
            coarseWrite_reg <= 1'b0;
        end else begin
            coarseWrite_reg <= wrCoarse;
            if (wrCoarse) begin
                coarseTarget_reg <= wrData[DELAY_W-1:0];
            end
            if (wrFine) begin
                fine_reg <= wrData[DELAY_W-1:0];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Coarse ramp and reference capture.

    logic [DELAY_W-1:0] coarseApplied;
    logic rampBusy;
    logic capturePulse;

    coarse_ramp rampUnit (
        .clock(clock),
        .resetSync_n(resetSync_n),
        .rampEnable(rampEn_reg),
        .rampFast(rampFast_reg),
        .targetWrite(coarseWrite_reg),
        .target(coarseTarget_reg),
        .applied(coarseApplied),
        .busy(rampBusy)
    );

    sysref_capture captureUnit (
        .clock(clock),
        .resetSync_n(resetSync_n),
        .sysrefIn(sysrefIn),
        .singleMode(single_reg),
        .positionSel(posSel_reg),
        .capturePulse(capturePulse)
    );

    logic seen_reg;
    logic [COUNT_W-1:0] refCount_reg;
    wire logic countFull = &refCount_reg;

    // The counter saturates so software never sees a wrapped, misleadingly small value.
    always_ff @(posedge clock or negedge resetSync_n) begin
        if (!resetSync_n) begin
            seen_reg <= 1'b0;
            refCount_reg <= '0;
        end else if (capturePulse) begin
            seen_reg <= 1'b1;
            refCount_reg <= countFull ? refCount_reg : refCount_reg + 16'h0001;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Clock tree outputs.

    wire delay_cfg_t delayNext = '{invert: invert_reg, coarse: coarseApplied, fine: fine_reg};
    wire sample_edges_t edgesNext = '{rise: 1'b1, fall: single_reg};

    delay_cfg_t delay_reg;
    sample_edges_t edges_reg;
    logic capture_reg;

    always_ff @(posedge clock or negedge resetSync_n) begin
        if (!resetSync_n) begin
            delay_reg <= '0;
            edges_reg <= '{rise: 1'b1, fall: 1'b0};
            capture_reg <= 1'b0;
        end else begin
            delay_reg <= delayNext;
            edges_reg <= edgesNext;
            capture_reg <= capturePulse;
        end
    end

    assign apertureDelay = delay_reg;
    assign sampleEdges = edges_reg;
    assign sysrefCapture = capture_reg;

////////////////////////////////////////////////////////////////////////////////
// Read path.

    wire logic [DATA_W-1:0] ctrlView = {
        {(DATA_W - CTRL_SEL_LSB - SEL_W){1'b0}}, posSel_reg,
        {(CTRL_SEL_LSB - CTRL_RAMP_FAST_BIT - 1){1'b0}},
        rampFast_reg, rampEn_reg, single_reg, invert_reg
    };
    wire logic [DATA_W-1:0] statusView = {
        {(DATA_W - STAT_SEEN_BIT - 1){1'b0}}, seen_reg, rampBusy, coarseApplied
    };
    wire logic [DATA_W-1:0] readMux =
        hitCtrl ? ctrlView :
        hitCoarse ? {{(DATA_W - DELAY_W){1'b0}}, coarseTarget_reg} :
        hitFine ? {{(DATA_W - DELAY_W){1'b0}}, fine_reg} :
        hitStatus ? statusView :
        hitCount ? {{(DATA_W - COUNT_W){1'b0}}, refCount_reg} :
        '0;

    logic [DATA_W-1:0] rdData_reg;

    always_ff @(posedge clock or negedge resetSync_n) begin
        if (!resetSync_n) begin
            rdData_reg <= '0;
        end else begin
            rdData_reg <= rdStrobe ? readMux : '0;
        end
    end

    assign rdData = rdData_reg;

////////////////////////////////////////////////////////////////////////////////
// Checks.

    a_dual_rise_only: assert property (@(posedge clock) disable iff (!resetSync_n)
        !single_reg |=> (sampleEdges.rise && !sampleEdges.fall))
        else $error("Dual-channel mode must sample on the rising edge only.");

    a_single_both_edges: assert property (@(posedge clock) disable iff (!resetSync_n)
        single_reg |=> (sampleEdges.rise && sampleEdges.fall))
        else $error("Single-channel mode must sample on both edges.");

    a_invert_to_tree: assert property (@(posedge clock) disable iff (!resetSync_n)
        wrCtrl ##1 !wrCtrl |=> (apertureDelay.invert == $past(wrData[CTRL_INV_BIT], 2)))
        else $error("Invert setting did not reach the clock tree.");

    a_fine_to_tree: assert property (@(posedge clock) disable iff (!resetSync_n)
        wrFine ##1 !wrFine |=> (apertureDelay.fine == $past(wrData[DELAY_W-1:0], 2)))
        else $error("Fine setting did not reach the clock tree.");

    a_coarse_direct: assert property (@(posedge clock) disable iff (!resetSync_n)
        (wrCoarse && !rampEn_reg) ##1 (!wrCoarse && !wrCtrl)[*2]
        |=> (apertureDelay.coarse == $past(coarseTarget_reg)))
        else $error("Coarse write without ramp did not apply.");

    a_ramp_holds: assert property (@(posedge clock) disable iff (!resetSync_n)
        (wrCoarse && rampEn_reg && !rampBusy && !wrCtrl && wrData[DELAY_W-1:0] != coarseApplied)
        |=> ##1 (coarseApplied == $past(coarseApplied, 2)))
        else $error("Ramped coarse write took effect at once.");

    a_ramp_starts: assert property (@(posedge clock) disable iff (!resetSync_n)
        (coarseWrite_reg && rampEn_reg && !wrCtrl && coarseTarget_reg != coarseApplied) |=> rampBusy)
        else $error("Coarse write with ramp enabled did not start a ramp.");

    a_ramp_ends: assert property (@(posedge clock) disable iff (!resetSync_n)
        (rampBusy && !wrCoarse && !wrCtrl && coarseApplied == coarseTarget_reg) |=> !rampBusy)
        else $error("Ramp did not stop at its target.");

    a_read_one_cycle: assert property (@(posedge clock) disable iff (!resetSync_n)
        !rdStrobe |=> (rdData == '0))
        else $error("Read data outside the answer cycle.");

    a_single_to_tree: assert property (@(posedge clock) disable iff (!resetSync_n)
        wrCtrl ##1 !wrCtrl |=> (sampleEdges.fall == $past(wrData[CTRL_SINGLE_BIT], 2)))
        else $error("Single-channel setting did not reach the edge enables.");

    a_fine_keeps_invert: assert property (@(posedge clock) disable iff (!resetSync_n)
        wrFine |=> ##1 (apertureDelay.invert == $past(apertureDelay.invert)))
        else $error("Fine write disturbed the invert setting.");

    a_coarse_keeps_fine: assert property (@(posedge clock) disable iff (!resetSync_n)
        wrCoarse |=> ##1 (apertureDelay.fine == $past(apertureDelay.fine)))
        else $error("Coarse write disturbed the fine setting.");

    a_ramp_off_follows: assert property (@(posedge clock) disable iff (!resetSync_n)
        !rampEn_reg |=> (coarseApplied == $past(coarseTarget_reg)))
        else $error("Coarse value did not follow its target with the ramp off.");

    a_ramp_one_step: assert property (@(posedge clock) disable iff (!resetSync_n)
        (rampEn_reg && $past(rampEn_reg) && coarseApplied != $past(coarseApplied))
        |-> (coarseApplied == $past(coarseApplied) + 8'h01 || coarseApplied == $past(coarseApplied) - 8'h01))
        else $error("Ramped coarse value moved by more than one step.");

    a_busy_needs_ramp: assert property (@(posedge clock) disable iff (!resetSync_n)
        (rampBusy && !rampEn_reg) |=> !rampBusy)
        else $error("Ramp kept running after it was disabled.");

    a_ramp_no_early: assert property (@(posedge clock) disable iff (!resetSync_n)
        (rampBusy && !wrCoarse && !wrCtrl) |=> (rampBusy || coarseApplied == coarseTarget_reg))
        else $error("Ramp stopped short of its target.");

    a_capture_delay: assert property (@(posedge clock) disable iff (!resetSync_n)
        capturePulse |=> sysrefCapture)
        else $error("Reference capture left the fixed pipeline.");

    a_capture_single: assert property (@(posedge clock) disable iff (!resetSync_n)
        sysrefCapture |=> !sysrefCapture)
        else $error("Reference capture pulse lasted more than one cycle.");

    a_capture_recorded: assert property (@(posedge clock) disable iff (!resetSync_n)
        capturePulse |=> (seen_reg && refCount_reg != '0))
        else $error("Capture not recorded in the status registers.");
endmodule
`default_nettype wire

// ===== hw/aperture_pkg.sv
// Shared constants and types for the aperture delay and reference capture block.
// Assumes a single 100 MHz clock domain and a plain strobed register port.
`default_nettype none
package aperture_pkg;
    // Register bus.
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] COARSE_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] FINE_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] REFCOUNT_OFS = 8'h10;
    // Control register fields.
    localparam int CTRL_INV_BIT = 0;
    localparam int CTRL_SINGLE_BIT = 1;
    localparam int CTRL_RAMP_EN_BIT = 2;
    localparam int CTRL_RAMP_FAST_BIT = 3;
    localparam int CTRL_SEL_LSB = 8;
    localparam int SEL_W = 4;
    // Status register fields.
    localparam int STAT_APPLIED_LSB = 0;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_SEEN_BIT = 9;
    // Delay codes: 256 settings each.
    localparam int DELAY_W = 8;
    localparam int COUNT_W = 16;
    // Reset values.
    localparam logic [DELAY_W-1:0] DELAY_RESET = 8'h00;
    localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
    // Clock period in ns; ramp timing in device clock cycles.
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int RAMP_SLOW_CYCLES = 256;
    localparam int RAMP_FAST_CYCLES = 384;
    localparam int RAMP_FAST_STEPS = 4;
    localparam int RAMP_FAST_GAP = RAMP_FAST_CYCLES / RAMP_FAST_STEPS;
    localparam int RAMP_CNT_W = 9;

    typedef struct packed {
        logic invert;
        logic [DELAY_W-1:0] coarse;
        logic [DELAY_W-1:0] fine;
    } delay_cfg_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } sample_edges_t;

    typedef enum logic [0:0] {
        RAMP_IDLE = 1'b0,
        RAMP_RUN = 1'b1
    } ramp_state_t;
endpackage
`default_nettype wire

// ===== hw/coarse_ramp.sv
// Coarse delay applicator with an optional gradual ramp toward the written target.
// Assumes an active-low reset from the parent's reset synchroniser, applied asynchronously and released in step with the clock.
`default_nettype none
module coarse_ramp
    import aperture_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic resetSync_n,
    // Control.
    input wire logic rampEnable,
    input wire logic rampFast,
    input wire logic targetWrite,
    input wire logic [DELAY_W-1:0] target,
    // Result.
    output logic [DELAY_W-1:0] applied,
    output logic busy
);
    ramp_state_t state_reg, state_next;
    logic [RAMP_CNT_W-1:0] cnt_reg, cnt_next;
    logic [DELAY_W-1:0] applied_reg, applied_next;
    wire logic [RAMP_CNT_W-1:0] lastCount = rampFast ? RAMP_CNT_W'(RAMP_FAST_GAP - 1)
                                                     : RAMP_CNT_W'(RAMP_SLOW_CYCLES - 1);
    wire logic atTarget = (applied_reg == target);
    wire logic stepNow = (state_reg == RAMP_RUN) && (cnt_reg >= lastCount);
    wire logic [DELAY_W-1:0] stepped = (applied_reg < target) ? applied_reg + 8'h01 : applied_reg - 8'h01;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        applied_next = applied_reg;
        case (state_reg)
            RAMP_IDLE: begin
                cnt_next = '0;
                if (!rampEnable) begin
                    applied_next = target;
                end else if (targetWrite && !atTarget) begin
                    state_next = RAMP_RUN;
                end
            end
            RAMP_RUN: begin
                // A rewrite only moves the target; the ramp keeps its present value and pace.
                if (!rampEnable) begin
                    applied_next = target;
                    state_next = RAMP_IDLE;
                end else if (atTarget) begin
                    state_next = RAMP_IDLE;
                end else if (stepNow) begin
                    applied_next = stepped;
                    cnt_next = '0;
                    if (stepped == target) begin
                        state_next = RAMP_IDLE;
                    end
                end else begin
                    cnt_next = cnt_reg + 9'h001;
                end
            end
            default: begin
                state_next = RAMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetSync_n) begin
        if (!resetSync_n) begin
            state_reg <= RAMP_IDLE;
            cnt_reg <= '0;
            applied_reg <= DELAY_RESET;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            applied_reg <= applied_next;
        end
    end

    assign applied = applied_reg;
    assign busy = (state_reg == RAMP_RUN);

    a_ramp_pace: assert property (@(posedge clock) disable iff (!resetSync_n)
        (rampEnable && $past(rampEnable) && applied_reg != $past(applied_reg))
        |-> ($past(cnt_reg) == $past(lastCount)))
        else $error("Coarse step taken off the ramp pace.");
endmodule
`default_nettype wire

// ===== hw/sysref_capture.sv
// Reference capture: delay taps, position select, dual-edge window and edge detect.
// Assumes the reference input is already synchronous to the device clock.
`default_nettype none
module sysref_capture
    import aperture_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic resetSync_n,
    // Reference and configuration.
    input wire logic sysrefIn,
    input wire logic singleMode,
    input wire logic [SEL_W-1:0] positionSel,
    // Result.
    output logic capturePulse
);
    localparam int TAPS = (1 << SEL_W) + 1;
    logic [TAPS-1:0] tap_reg;
    logic prev_reg;
    logic pulse_reg;
    wire logic [SEL_W:0] selNext = {1'b0, positionSel} + 5'h01;
    // Dual-edge sampling spans two half periods, so the window covers two taps.
    wire logic windowed = tap_reg[positionSel] | (singleMode & tap_reg[selNext]);
    wire logic risingRef = windowed & ~prev_reg;

    always_ff @(posedge clock or negedge resetSync_n) begin
        if (!resetSync_n) begin
            tap_reg <= '0;
            prev_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            tap_reg <= {tap_reg[TAPS-2:0], sysrefIn};
            prev_reg <= windowed;
            pulse_reg <= risingRef;
        end
    end

    assign capturePulse = pulse_reg;

    a_ref_edge: assert property (@(posedge clock) disable iff (!resetSync_n)
        capturePulse |-> ($past(windowed) && !$past(prev_reg)))
        else $error("Reference captured without a rising edge.");
endmodule
`default_nettype wire

// ===== test/sysref_source.sv
// Behavioural clock source: drives the timing reference as a lone pulse or a periodic train.
// Assumes the bench raises its requests right after a rising clock edge.
`default_nettype none
module sysref_source #(
    parameter int FRAME_CYCLES = 8,
    parameter int DIVIDE = 1
) (
    // Clock.
    input wire logic clock,
    // Requests from the bench.
    input wire logic pulseReq,
    input wire logic periodicEn,
    // Reference to the block.
    output logic sysrefOut
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PERIOD = FRAME_CYCLES * DIVIDE;
    int phase = 0;
    int pulseLeft = 0;
    logic level = 1'b0;
    assign sysrefOut = level;
    // Edge-aligned so the reference phase is the same on every run.
    always @(posedge clock) begin
        if (pulseReq) begin
            pulseLeft = 2;
        end
        if (periodicEn) begin
            level <= (phase == 0);
            phase = (phase + 1) % PERIOD;
        end else begin
            phase = 0;
            level <= (pulseLeft > 0);
            if (pulseLeft > 0) begin
                pulseLeft--;
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the aperture delay and reference capture block.
// Assumes the package, the design files and the reference source model are compiled first.
`default_nettype none
module tb
    import aperture_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wrData = '0;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic [DATA_W-1:0] rdData;
    logic sysrefIn;
    logic pulseReq = 1'b0;
    logic periodicEn = 1'b0;
    delay_cfg_t apertureDelay;
    sample_edges_t sampleEdges;
    logic sysrefCapture;
    int num_errors = 0;
    int num_checks = 0;
    int capCount = 0;
    int lat0;
    int lat1;
    int gap;
    int base;

    initial begin
        forever #5 clock = ~clock;
    end

    aperture_clock_ctrl dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .sysrefIn(sysrefIn),
        .apertureDelay(apertureDelay), .sampleEdges(sampleEdges), .sysrefCapture(sysrefCapture));

    sysref_source #(.FRAME_CYCLES(8), .DIVIDE(1)) source (.clock(clock), .pulseReq(pulseReq),
        .periodicEn(periodicEn), .sysrefOut(sysrefIn));

    // Sampled mid-cycle so the count never races the edge that launches the pulse.
    always @(negedge clock) begin
        if (sysrefCapture === 1'b1) begin
            capCount++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_count(string what, int exp, int got);
        num_checks++;
        if (got != exp) begin
            num_errors++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic reg_write(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clock);
        wrStrobe <= 1'b0;
    endtask

    task automatic check_reg(string what, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] exp);
        @(posedge clock);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
        #1;
        check_val(what, exp, rdData);
    endtask

    task automatic settle(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Counts edges until the applied coarse code moves; bounded so a stuck ramp cannot hang.
    task automatic wait_change(output int n);
        logic [DELAY_W-1:0] prev;
        prev = apertureDelay.coarse;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (apertureDelay.coarse === prev && n < 400);
    endtask

    task automatic pulse_latency(output int n);
        @(posedge clock);
        pulseReq <= 1'b1;
        @(posedge clock);
        pulseReq <= 1'b0;
        n = 0;
        #1;
        while (sysrefCapture !== 1'b1 && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        settle(1);
        check_val("capture pulse width", 32'h0000_0000, 32'(sysrefCapture));
        settle(6);
    endtask

    task automatic periodic_run(int periods);
        base = capCount;
        @(posedge clock);
        periodicEn <= 1'b1;
        repeat (periods * 8) @(posedge clock);
        periodicEn <= 1'b0;
        settle(12);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        num_errors++;
        $display("Watchdog expired");
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        settle(3);
        check_val("delay at reset", 32'h0000_0000, 32'(apertureDelay));
        check_val("edges at reset", 32'h0000_0002, 32'(sampleEdges));
        check_reg("status at reset", STATUS_OFS, 32'h0000_0000);
        $display("Test reset done");

        reg_write(CTRL_OFS, 32'h0000_0002);
        settle(3);
        check_val("edges single", 32'h0000_0003, 32'(sampleEdges));
        reg_write(CTRL_OFS, 32'h0000_0000);
        settle(3);
        check_val("edges dual", 32'h0000_0002, 32'(sampleEdges));
        $display("Test sampling edges done");

        reg_write(FINE_OFS, 32'h0000_00FF);
        reg_write(CTRL_OFS, 32'h0000_0001);
        reg_write(COARSE_OFS, 32'h0000_0010);
        settle(4);
        check_val("delay combined", 32'h0001_10FF, 32'(apertureDelay));
        check_reg("fine readback", FINE_OFS, 32'h0000_00FF);
        check_reg("unmapped read", 8'h14, 32'h0000_0000);
        $display("Test delay codes done");

        reg_write(CTRL_OFS, 32'h0000_0004);
        reg_write(COARSE_OFS, 32'h0000_0012);
        settle(10);
        check_val("no jump", 32'h0000_0010, 32'(apertureDelay.coarse));
        check_reg("status ramping", STATUS_OFS, 32'h0000_0110);
        wait_change(gap);
        check_val("slow step one", 32'h0000_0011, 32'(apertureDelay.coarse));
        wait_change(gap);
        check_count("slow step gap", RAMP_SLOW_CYCLES, gap);
        check_val("slow end", 32'h0000_0012, 32'(apertureDelay.coarse));
        settle(2);
        check_reg("status idle", STATUS_OFS, 32'h0000_0012);
        $display("Test slow ramp done");

        reg_write(CTRL_OFS, 32'h0000_000C);
        reg_write(COARSE_OFS, 32'h0000_000E);
        wait_change(gap);
        check_val("fast down one", 32'h0000_0011, 32'(apertureDelay.coarse));
        wait_change(gap);
        check_count("fast step gap", RAMP_FAST_GAP, gap);
        reg_write(COARSE_OFS, 32'h0000_0014);
        wait_change(gap);
        check_val("retarget step", 32'h0000_0011, 32'(apertureDelay.coarse));
        repeat (3) wait_change(gap);
        check_val("retarget end", 32'h0000_0014, 32'(apertureDelay.coarse));
        reg_write(COARSE_OFS, 32'h0000_0040);
        reg_write(CTRL_OFS, 32'h0000_0000);
        settle(4);
        check_val("ramp off jump", 32'h0000_0040, 32'(apertureDelay.coarse));
        $display("Test fast ramp done");

        pulse_latency(lat0);
        check_count("capture latency", 3, lat0);
        pulse_latency(lat1);
        check_count("repeat latency", lat0, lat1);
        reg_write(CTRL_OFS, 32'h0000_0200);
        pulse_latency(lat1);
        check_count("position latency", lat0 + 2, lat1);
        reg_write(CTRL_OFS, 32'h0000_0000);
        periodic_run(5);
        check_count("periodic dual", 5, capCount - base);
        reg_write(CTRL_OFS, 32'h0000_0002);
        periodic_run(5);
        check_count("periodic single", 5, capCount - base);
        check_reg("capture count", REFCOUNT_OFS, 32'h0000_000D);
        check_reg("status seen", STATUS_OFS, 32'h0000_0240);
        $display("Test reference capture done");
        end_of_test();
    end
endmodule
`default_nettype wire
